//--- bench/tb_zhc_zone_heating_control.sv
// Self-checking bench for the zone heating control block.
`timescale 1ns/1ps
`default_nettype none
`include "zhc_consts.vh"
module tb_zhc_zone_heating_control;
  // Stimulus into the block.
  logic        mclk_in, reset_in, sensor_enable_in, timed_active_in, smooth_valve_modulation_in;
  logic        protection_in, alarm_in, window_open_in, reg_start_in, delete_all_in, button;
  logic        zone_selected_in, remote_registered_in;
  logic [11:0] room_temp_in, outdoor_temp_in, zone_setpoint_in, holiday_temp_in, sp;
  logic [11:0] eco_temp_in, comfort_temp_in, timed_setpoint_in;
  logic [7:0]  cal_offset_in, hysteresis_in, range_in, answer_wait;
  logic [6:0]  min_open_in, max_open_in, emergency_open_in;
  logic [1:0]  op_mode_in, led_mode_in;
  logic [10:0] window_delay_sec_in;
  logic [2:0]  act_report_idx_in;
  logic [15:0] contact_delay_ticks_in;
  // Results from the block and the field model.
  wire  [6:0]  valve_open_out;
  wire  [2:0]  act_count_out, act_report_sel_out;
  wire  [11:0] outdoor_display_out;
  wire         underheat_out, reg_busy_out, reg_ok_out, reg_fail_out, act_report_out;
  wire         contact_out, remote_contact_out, led_out, reg_answer_in, act_report_req_in;
  int          err_total, num_checks, i, n;
  logic        hit;
  always #2 mclk_in = ~mclk_in;
  // Short timebase keeps timeouts brief.
  zhc_zone_heating_control #(.TICK_CYC(4), .REG_TICKS(5)) zhc_zone_heating_control_i (.*);
  zhc_field_model #(.HOLD_CYC(8)) zhc_field_model_i (.mclk_in(mclk_in), .reset_in(reset_in),
    .reg_busy_in(reg_busy_out), .button_in(button), .answer_wait_in(answer_wait),
    .reg_answer_out(reg_answer_in), .report_req_out(act_report_req_in));
  task automatic cyc(input int k);
    repeat (k) @(negedge mclk_in);
  endtask
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Bounded wait for a result.
  task automatic wait_for(input int sel, input int k, output logic seen);
    seen = 1'b0;
    repeat (k) begin
      if ((sel == 0 ? reg_ok_out : sel == 1 ? reg_fail_out : sel == 2 ? act_report_out
          : contact_out) === 1'b1) seen = 1'b1;
      if (!seen) cyc(1);
    end
  endtask
  task automatic toggles(input int k, output int cnt);
    logic last;
    cnt = 0;
    last = led_out;
    repeat (k) begin
      cyc(1);
      if (led_out !== last) cnt++;
      last = led_out;
    end
  endtask
  // Offset the reading so the calibrated value is t.
  task automatic set_temp(input logic [11:0] t);
    room_temp_in = t - {{4{cal_offset_in[7]}}, cal_offset_in};
    cyc(4);
  endtask
  task automatic pulse_start;
    reg_start_in = 1'b1;
    cyc(1);
    reg_start_in = 1'b0;
  endtask
  function automatic logic [11:0] exp_sp();
    case (op_mode_in)
      `ZHC_MODE_HOLIDAY: exp_sp = holiday_temp_in;
      `ZHC_MODE_ECO: exp_sp = eco_temp_in;
      `ZHC_MODE_COMFORT: exp_sp = comfort_temp_in;
      default: exp_sp = timed_active_in ? timed_setpoint_in : zone_setpoint_in;
    endcase
  endfunction
  task end_of_test;
    $display("Comparisons %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    {reset_in, sensor_enable_in, mclk_in, timed_active_in, alarm_in} = 5'b11000;
    {smooth_valve_modulation_in, protection_in, window_open_in, reg_start_in, button} = '0;
    {delete_all_in, zone_selected_in, remote_registered_in, op_mode_in, led_mode_in} = '0;
    {room_temp_in, outdoor_temp_in, zone_setpoint_in, holiday_temp_in, eco_temp_in} = '0;
    {comfort_temp_in, timed_setpoint_in, cal_offset_in, answer_wait, act_report_idx_in} = '0;
    {min_open_in, max_open_in, emergency_open_in, window_delay_sec_in} = '0;
    {hysteresis_in, range_in, contact_delay_ticks_in} = {8'h05, 8'h28, 16'h0003};
    {err_total, num_checks} = '0;
    n = $urandom(7430);
    cyc(6);
    reset_in = 1'b0;
    // Demand band per setpoint source; hysteresis limits first.
    for (i = 0; i < 8; i++) begin
      op_mode_in = i[1:0];
      timed_active_in = (i == 4);
      zone_setpoint_in = 12'(200 + $urandom % 60);
      holiday_temp_in = zone_setpoint_in - 12'h014;
      eco_temp_in = zone_setpoint_in + 12'h00A;
      comfort_temp_in = zone_setpoint_in + 12'h01E;
      timed_setpoint_in = zone_setpoint_in - 12'h01E;
      cal_offset_in = 8'($urandom % 201 - 100);
      hysteresis_in = (i == 0) ? 8'h01 : (i == 1) ? 8'h64 : 8'(1 + $urandom % 29);
      min_open_in = 7'(10 + $urandom % 30);
      max_open_in = 7'(60 + $urandom % 40);
      outdoor_temp_in = 12'($urandom);
      sp = exp_sp();
      set_temp(sp);
      chk("demand at setpoint", 12'h000, underheat_out);
      chk("valve idle", min_open_in, valve_open_out);
      chk("outdoor shown", outdoor_temp_in, outdoor_display_out);
      set_temp(sp - hysteresis_in + 12'h001);
      chk("demand inside band", 12'h000, underheat_out);
      set_temp(sp - hysteresis_in);
      chk("demand at low edge", 12'h001, underheat_out);
      chk("valve on demand", max_open_in, valve_open_out);
      sensor_enable_in = 1'b0;
      set_temp(sp + 12'h032);
      chk("demand sensor off", 12'h001, underheat_out);
      sensor_enable_in = 1'b1;
      set_temp(sp - 12'h001);
      chk("demand held", 12'h001, underheat_out);
      set_temp(sp);
      chk("demand cleared", 12'h000, underheat_out);
      if (i == 4) begin
        timed_active_in = 1'b0;
        set_temp(zone_setpoint_in - hysteresis_in);
        chk("demand after expiry", 12'h001, underheat_out);
      end
    end
    // Seventh registration is refused.
    for (i = 1; i <= 7; i++) begin
      answer_wait = 8'(1 + $urandom % 10);
      pulse_start();
      wait_for((i == 7) ? 1 : 0, 40, hit);
      chk("registration result", 12'h001, hit);
      cyc(1);
      chk("actuator count", (i == 7) ? 12'h006 : 12'(i), act_count_out);
    end
    act_report_idx_in = 3'($urandom % 6);
    button = 1'b1;
    wait_for(2, 20, hit);
    chk("report pulse", 12'h001, hit);
    chk("report index", act_report_idx_in, act_report_sel_out);
    button = 1'b0;
    act_report_idx_in = 3'h7;
    cyc(1);
    button = 1'b1;
    wait_for(2, 20, hit);
    chk("report refused", 12'h000, hit);
    {button, delete_all_in} = 2'b01;
    cyc(1);
    delete_all_in = 1'b0;
    cyc(1);
    chk("count cleared", 12'h000, act_count_out);
    answer_wait = 8'h00;
    pulse_start();
    chk("registration busy", 12'h001, reg_busy_out);
    wait_for(1, 40, hit);
    chk("registration timeout", 12'h001, hit);
    // Window delay, zero delay and alarm opening.
    sp = exp_sp();
    set_temp(sp - hysteresis_in);
    {window_delay_sec_in, window_open_in} = {11'h001, 1'b1};
    cyc(30);
    chk("valve inside delay", max_open_in, valve_open_out);
    cyc(25);
    chk("valve after delay", 12'h000, valve_open_out);
    window_open_in = 1'b0;
    cyc(8);
    chk("valve window shut", max_open_in, valve_open_out);
    {window_delay_sec_in, window_open_in} = {11'h000, 1'b1};
    cyc(6);
    chk("valve no delay", 12'h000, valve_open_out);
    emergency_open_in = min_open_in + 7'h05;
    alarm_in = 1'b1;
    cyc(4);
    chk("valve alarm", emergency_open_in, valve_open_out);
    {alarm_in, window_open_in, smooth_valve_modulation_in} = 3'b001;
    cyc(4);
    set_temp(sp - 12'h028);
    chk("valve ramp full", max_open_in, valve_open_out);
    set_temp(sp);
    chk("valve ramp end", min_open_in, valve_open_out);
    protection_in = 1'b1;
    set_temp(sp + 12'h029);
    chk("valve protected", 12'h000, valve_open_out);
    {smooth_valve_modulation_in, protection_in, remote_registered_in} = 3'b001;
    led_mode_in = `ZHC_LED_CONTACT;
    set_temp(sp - hysteresis_in);
    cyc(20);
    chk("contact unselected", 12'h000, contact_out);
    zone_selected_in = 1'b1;
    cyc(6);
    chk("contact delayed", 12'h000, contact_out);
    wait_for(3, 20, hit);
    chk("contact closed", 12'h001, hit);
    cyc(2);
    chk("remote closed", 12'h001, remote_contact_out);
    toggles(60, n);
    chk("led blink closed", 12'h001, n > 1);
    set_temp(sp);
    cyc(2);
    chk("remote open", 12'h000, remote_contact_out);
    toggles(30, n);
    chk("led steady open", 12'h001, led_out && n == 0);
    led_mode_in = `ZHC_LED_HEAT;
    set_temp(sp - hysteresis_in);
    toggles(60, n);
    chk("led blink demand", 12'h001, n > 1);
    {led_mode_in, alarm_in} = {`ZHC_LED_ALARM, 1'b1};
    toggles(60, n);
    chk("led blink alarm", 12'h001, n > 1);
    end_of_test();
  end
endmodule
`default_nettype wire

//--- bench/zhc_field_model.sv
// Field-side model: actuators answering registration and a held report button.
`timescale 1ns/1ps
`default_nettype none
module zhc_field_model #(
  parameter integer HOLD_CYC = 8  // Hold that stands for the two-second press.
) (
  // Clock and reset shared with the block.
  input  wire logic       mclk_in,
  input  wire logic       reset_in,
  // Registration window and user stimulus.
  input  wire logic       reg_busy_in,
  input  wire logic       button_in,
  input  wire logic [7:0] answer_wait_in,
  // Pulses towards the block.
  output var logic        reg_answer_out,
  output var logic        report_req_out
);
  int wait_cnt;  // Cycles spent in the registration window.
  int hold_cnt;  // Cycles the report button has been held.
  // Outputs change just after the rising edge.
  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      {reg_answer_out, report_req_out} <= 2'b00;
      wait_cnt <= 0;
      hold_cnt <= 0;
    end else begin
      reg_answer_out <= 1'b0;
      // Zero wait: the actuator never answers.
      if (!reg_busy_in || reg_answer_out) begin
        wait_cnt <= 0;
      end else if (answer_wait_in != 8'h00) begin
        wait_cnt <= wait_cnt + 1;
        reg_answer_out <= (wait_cnt + 1 == answer_wait_in);
      end
      // One request per press, at the hold time.
      hold_cnt <= button_in ? hold_cnt + 1 : 0;
      report_req_out <= button_in && (hold_cnt + 1 == HOLD_CYC);
    end
  end
endmodule
`default_nettype wire

//--- bench/zhc_zone_heating_control_assertions.sv
// Checker watching the ports of the zone heating control block.
`timescale 1ns/1ps
`default_nettype none
module zhc_checker (
  // Clock and reset.
  input wire logic        mclk_in,
  input wire logic        reset_in,
  // Stimulus seen by the block.
  input wire logic        alarm_in,
  input wire logic [6:0]  emergency_open_in,
  input wire logic        window_open_in,
  input wire logic [10:0] window_delay_sec_in,
  input wire logic        reg_start_in,
  input wire logic        reg_answer_in,
  input wire logic        delete_all_in,
  input wire logic        zone_selected_in,
  input wire logic        remote_registered_in,
  input wire logic [11:0] outdoor_temp_in,
  // Results driven by the block.
  input wire logic [6:0]  valve_open_out,
  input wire logic [2:0]  act_count_out,
  input wire logic        reg_busy_out,
  input wire logic        reg_ok_out,
  input wire logic        reg_fail_out,
  input wire logic        contact_out,
  input wire logic        remote_contact_out,
  input wire logic [11:0] outdoor_display_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  // An alarm held long enough to pass the one-cycle valve path.
  sequence alarm_held;
    (alarm_in && $stable(emergency_open_in)) [*4];
  endsequence
  // An open window with no delay, held past the three-stage synchroniser.
  sequence window_now;
    (window_open_in && window_delay_sec_in == 11'h000 && !alarm_in) [*7];
  endsequence
  full_refuse_a: assert property (reg_start_in && !reg_busy_out && act_count_out == 3'h6
    && !delete_all_in |=> reg_fail_out) else $error("full zone accepted");
  reg_accept_a: assert property (reg_answer_in && reg_busy_out && !delete_all_in |=>
    reg_ok_out && !reg_busy_out && act_count_out == $past(act_count_out) + 3'h1)
    else $error("answer not counted");
  delete_clear_a: assert property (delete_all_in |=> act_count_out == 3'h0)
    else $error("delete left actuators");
  count_limit_a: assert property (act_count_out <= 3'h6)
    else $error("over six actuators");
  ok_pulse_a: assert property (reg_ok_out |=> !reg_ok_out && !reg_busy_out)
    else $error("ok not one pulse");
  alarm_open_a: assert property (alarm_held |-> valve_open_out == emergency_open_in)
    else $error("no emergency opening");
  window_close_a: assert property (window_now |-> valve_open_out == 7'h00)
    else $error("window left valve open");
  unselected_off_a: assert property ((!zone_selected_in) [*3] |-> !contact_out)
    else $error("unselected zone contact");
  remote_mirror_a: assert property (remote_contact_out ==
    ($past(contact_out) && $past(remote_registered_in))) else $error("remote contact differs");
  outdoor_copy_a: assert property (!$past(reset_in) |->
    outdoor_display_out == $past(outdoor_temp_in)) else $error("outdoor not copied");
endmodule
bind zhc_zone_heating_control zhc_checker zhc_checker_i (.*);
`default_nettype wire

//--- logic/zhc_zone_heating_control.v
// Zone heating regulator: demand, valve command, window, contact and LED logic.
//
// Functional notes
// [R1] Hysteresis 0.1 to 10 degrees, 0.1 step.
// [R2] Underheat set at setpoint minus hysteresis.
// [R3] Signed calibration offset added to reading.
// [R4] At most six actuators registered per zone.
// [R5] Delete-all clears every actuator registration.
// [R6] Actuator button hold requests its report.
// [R7] Valve opening clamped between minimum and maximum.
// [R8] Rising: close from setpoint-range to setpoint.
// [R9] Falling: open from setpoint-hyst to setpoint-range.
// [R10] Protection closes valves above setpoint plus range.
// [R11] Alarm commands the emergency opening.
// [R12] Window open: wait delay, then close.
// [R13] Zero window delay closes at once.
// [R14] Setpoint from zone mode or per-mode temperature.
// [R15] Timed setpoint expiry reverts to earlier setpoint.
// [R16] Disabled room sensor reading is not used.
// [R17] Unselected zone ignored for the contact.
// [R18] Activation delay before closing the contact.
// [R19] Remote contact mirrors the built-in contact.
// [R20] Contact mode: blink closed, steady open.
// [R21] Heat mode blinks on demand; alarm blinks.
// [R22] Outdoor reading never used for control.
// [R23] Demand cleared once temperature reaches setpoint.
// [R24] Registration fails without answer in 120 s.
`timescale 1ns/1ps
`default_nettype none
`include "zhc_consts.vh"
module zhc_zone_heating_control #(
  parameter integer TICK_CYC  = `ZHC_TICK_CYC,   // Cycles per 0.1 s timebase tick.
  parameter integer REG_TICKS = `ZHC_REG_TICKS   // Registration answer window in ticks.
) (
  // Clock and reset.
  input  wire        mclk_in,
  input  wire        reset_in,
  // Room sensor and calibration.
  input  wire [11:0] room_temp_in,
  input  wire        sensor_enable_in,
  input  wire [7:0]  cal_offset_in,
  input  wire [11:0] outdoor_temp_in,
  // Setpoint selection.
  input  wire [1:0]  op_mode_in,
  input  wire [11:0] zone_setpoint_in,
  input  wire [11:0] holiday_temp_in,
  input  wire [11:0] eco_temp_in,
  input  wire [11:0] comfort_temp_in,
  input  wire        timed_active_in,
  input  wire [11:0] timed_setpoint_in,
  // Regulation settings.
  input  wire [7:0]  hysteresis_in,
  input  wire [7:0]  range_in,
  input  wire [6:0]  min_open_in,
  input  wire [6:0]  max_open_in,
  input  wire [6:0]  emergency_open_in,
  input  wire        smooth_valve_modulation_in,
  input  wire        protection_in,
  input  wire        alarm_in,
  // Window sensor.
  input  wire        window_open_in,
  input  wire [10:0] window_delay_sec_in,
  // Actuator registration.
  input  wire        reg_start_in,
  input  wire        reg_answer_in,
  input  wire        delete_all_in,
  input  wire        act_report_req_in,
  input  wire [2:0]  act_report_idx_in,
  // Heat-request contact.
  input  wire        zone_selected_in,
  input  wire [15:0] contact_delay_ticks_in,
  input  wire        remote_registered_in,
  input  wire [1:0]  led_mode_in,
  // Outputs.
  output reg  [6:0]  valve_open_out,
  output reg         underheat_out,
  output reg  [2:0]  act_count_out,
  output reg         reg_busy_out,
  output reg         reg_ok_out,
  output reg         reg_fail_out,
  output reg         act_report_out,
  output reg  [2:0]  act_report_sel_out,
  output reg         contact_out,
  output reg         remote_contact_out,
  output reg         led_out,
  output reg  [11:0] outdoor_display_out
);

  // Window delay in seconds, converted to ticks (ten per second).
  localparam integer WIN_MAX_SEC = `ZHC_WIN_MAX_MIN * 60;

  // Window pin synchroniser, three stages.
  reg [2:0] win_sync;
  // Debounced window level, changed only when stages two and three agree.
  reg       win_level;

  // Timebase divider producing one-cycle tick enables.
  reg [31:0] tick_cnt;
  reg        tick;

  // Held room reading, retained when the sensor is disabled.
  reg signed [12:0] room_cal;
  // Active setpoint, chosen by mode and timed override.
  reg signed [12:0] setpoint;
  // Hysteresis and offset clamped into their legal ranges.
  reg [7:0] hyst_eff;
  reg signed [7:0] cal_eff;
  // Derived thresholds.
  reg signed [13:0] thr_low;    // Setpoint minus hysteresis.
  reg signed [13:0] thr_range;  // Setpoint minus range.
  reg signed [13:0] thr_prot;   // Setpoint plus range.
  // Proportional opening computed combinationally.
  reg [6:0] lo_open;
  reg [6:0] hi_open;
  reg [6:0] next_valve;
  reg [20:0] ramp;
  // Direction memory for the two ramps.
  reg rising;
  reg signed [12:0] prev_temp;
  // Window delay counter and close request.
  reg [15:0] win_cnt;
  reg        win_close;
  // Registration timer.
  reg [15:0] reg_cnt;
  // Contact delay counter.
  reg [15:0] con_cnt;
  // Blink timer.
  reg [3:0]  blink_cnt;
  reg        blink;

  // Window pin synchroniser and filter.
  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      win_sync  <= 3'h0;
      win_level <= 1'b0;
    end else begin
      win_sync <= {win_sync[1:0], window_open_in};
      // A change is accepted only once the last two stages agree.
      if (win_sync[1] == win_sync[2]) begin
        win_level <= win_sync[2];
      end
    end
  end

  // Timebase divider: one pulse per 0.1 s.
  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b0;
    end else if (tick_cnt >= TICK_CYC - 1) begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
      tick     <= 1'b0;
    end
  end

  // Setting clamps and setpoint selection.
  always @* begin
    // Hysteresis is held within 0.1 to 10 degrees. [R1]
    if (hysteresis_in < `ZHC_HYST_MIN) begin
      hyst_eff = `ZHC_HYST_MIN;
    end else if (hysteresis_in > `ZHC_HYST_MAX) begin
      hyst_eff = `ZHC_HYST_MAX;
    end else begin
      hyst_eff = hysteresis_in;
    end
    // Offset is held within -10 to +10 degrees. [R3]
    if ($signed(cal_offset_in) < $signed(`ZHC_CAL_MIN)) begin
      cal_eff = $signed(`ZHC_CAL_MIN);
    end else if ($signed(cal_offset_in) > $signed(`ZHC_CAL_MAX)) begin
      cal_eff = $signed(`ZHC_CAL_MAX);
    end else begin
      cal_eff = $signed(cal_offset_in);
    end
    // In normal mode the timed setpoint overrides; on expiry the zone setpoint is used again. [R15]
    case (op_mode_in) // [R14]
      `ZHC_MODE_HOLIDAY: setpoint = $signed({holiday_temp_in[11], holiday_temp_in});
      `ZHC_MODE_ECO:     setpoint = $signed({eco_temp_in[11], eco_temp_in});
      `ZHC_MODE_COMFORT: setpoint = $signed({comfort_temp_in[11], comfort_temp_in});
      default: begin
        if (timed_active_in) begin
          setpoint = $signed({timed_setpoint_in[11], timed_setpoint_in});
        end else begin
          setpoint = $signed({zone_setpoint_in[11], zone_setpoint_in});
        end
      end
    endcase
    thr_low   = $signed({setpoint[12], setpoint}) - $signed({6'h00, hyst_eff});
    thr_range = $signed({setpoint[12], setpoint}) - $signed({6'h00, range_in});
    thr_prot  = $signed({setpoint[12], setpoint}) + $signed({6'h00, range_in});
  end

  // Calibrated reading, frozen while the sensor is disabled.
  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      room_cal  <= 13'h0000;
      prev_temp <= 13'h0000;
      rising    <= 1'b0;
    end else if (sensor_enable_in) begin // [R16]
      room_cal  <= $signed({room_temp_in[11], room_temp_in}) + $signed({{5{cal_eff[7]}}, cal_eff}); // [R3]
      prev_temp <= room_cal;
      if (room_cal > prev_temp) begin
        rising <= 1'b1;
      end else if (room_cal < prev_temp) begin
        rising <= 1'b0;
      end
    end
  end

  // Proportional opening between min and max with clamps and overrides.
  always @* begin
    // Limits are reordered if set crossed, so the clamp never inverts. [R7]
    lo_open = (min_open_in < max_open_in) ? min_open_in : max_open_in;
    hi_open = (min_open_in < max_open_in) ? max_open_in : min_open_in;
    ramp    = 21'h00_0000;
    next_valve = hi_open;
    if (alarm_in) begin
      next_valve = emergency_open_in; // [R11]
    end else if (win_close) begin
      next_valve = 7'h00; // [R12]
    end else if (smooth_valve_modulation_in && protection_in
                 && {room_cal[12], room_cal} > thr_prot) begin
      next_valve = 7'h00; // [R10]
    end else if (!smooth_valve_modulation_in) begin
      // Plain on/off from the demand flag.
      next_valve = underheat_out ? hi_open : lo_open;
    end else if (rising) begin
      // Ramp down from setpoint-range to setpoint. [R8]
      if ({room_cal[12], room_cal} <= thr_range || range_in == 8'h00) begin
        next_valve = (range_in == 8'h00 && room_cal >= setpoint) ? lo_open : hi_open;
      end else if (room_cal >= setpoint) begin
        next_valve = lo_open;
      end else begin
        ramp = ({14'h0000, hi_open - lo_open}
                * {8'h00, setpoint - room_cal}) / {13'h0000, range_in};
        next_valve = lo_open + ramp[6:0];
      end
    end else begin
      // Ramp up from setpoint-hysteresis to setpoint-range. [R9]
      if ({room_cal[12], room_cal} <= thr_range) begin
        next_valve = hi_open;
      end else if ({room_cal[12], room_cal} >= thr_low || range_in <= {1'b0, hyst_eff}) begin
        next_valve = ({room_cal[12], room_cal} >= thr_low) ? lo_open : hi_open;
      end else begin
        ramp = ({14'h0000, hi_open - lo_open}
                * {7'h00, thr_low - {room_cal[12], room_cal}})
               / {13'h0000, range_in - hyst_eff};
        next_valve = lo_open + ramp[6:0];
      end
    end
    // Openings other than the alarm, window and protection overrides respect the limits. [R7]
    if (!alarm_in && !win_close && next_valve != 7'h00) begin
      if (next_valve < lo_open) next_valve = lo_open;
      if (next_valve > hi_open) next_valve = hi_open;
    end
  end

  // Demand flag and valve command registers.
  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      underheat_out       <= 1'b0;
      valve_open_out      <= 7'h00;
      outdoor_display_out <= 12'h000;
    end else begin
      // Outdoor reading only reaches the display path. [R22]
      outdoor_display_out <= outdoor_temp_in;
      valve_open_out      <= next_valve;
      if ({room_cal[12], room_cal} <= thr_low) begin
        underheat_out <= 1'b1; // [R2]
      end else if (room_cal >= setpoint) begin
        underheat_out <= 1'b0; // [R23]
      end
    end
  end

  // Window delay: counts ticks while open, closes valves when it expires.
  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      win_cnt   <= 16'h0000;
      win_close <= 1'b0;
    end else if (!win_level) begin
      win_cnt   <= 16'h0000;
      win_close <= 1'b0;
    end else if (window_delay_sec_in == 11'h000) begin
      win_close <= 1'b1; // [R13]
    end else if (win_cnt >= {5'h00, ((window_delay_sec_in > WIN_MAX_SEC[10:0]) ?
                 WIN_MAX_SEC[10:0] : window_delay_sec_in)} * 16'h000A) begin
      win_close <= 1'b1; // [R12]
    end else if (tick) begin
      win_cnt <= win_cnt + 16'h0001;
    end
  end

  // Actuator registration, deletion and report requests.
  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      act_count_out      <= 3'h0;
      reg_busy_out       <= 1'b0;
      reg_ok_out         <= 1'b0;
      reg_fail_out       <= 1'b0;
      reg_cnt            <= 16'h0000;
      act_report_out     <= 1'b0;
      act_report_sel_out <= 3'h0;
    end else begin
      reg_ok_out     <= 1'b0;
      reg_fail_out   <= 1'b0;
      act_report_out <= 1'b0;
      // A held button on a known actuator presents its report. [R6]
      if (act_report_req_in && act_report_idx_in < act_count_out) begin
        act_report_out     <= 1'b1;
        act_report_sel_out <= act_report_idx_in;
      end
      if (delete_all_in) begin
        act_count_out <= 3'h0; // [R5]
        reg_busy_out  <= 1'b0;
      end else if (reg_start_in && !reg_busy_out) begin
        if (act_count_out >= `ZHC_MAX_ACT) begin
          reg_fail_out <= 1'b1; // [R4]
        end else begin
          reg_busy_out <= 1'b1;
          reg_cnt      <= 16'h0000;
        end
      end else if (reg_busy_out) begin
        if (reg_answer_in) begin
          reg_busy_out  <= 1'b0;
          reg_ok_out    <= 1'b1;
          act_count_out <= act_count_out + 3'h1;
        end else if (reg_cnt >= REG_TICKS[15:0]) begin
          reg_busy_out <= 1'b0;
          reg_fail_out <= 1'b1; // [R24]
        end else if (tick) begin
          reg_cnt <= reg_cnt + 16'h0001;
        end
      end
    end
  end

  // Heat-request contact with activation delay and remote mirror.
  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      con_cnt            <= 16'h0000;
      contact_out        <= 1'b0;
      remote_contact_out <= 1'b0;
    end else begin
      // Remote follows the built-in contact when registered. [R19]
      remote_contact_out <= remote_registered_in & contact_out;
      if (!(zone_selected_in && underheat_out)) begin // [R17]
        con_cnt     <= 16'h0000;
        contact_out <= 1'b0;
      end else if (con_cnt >= contact_delay_ticks_in) begin
        contact_out <= 1'b1; // [R18]
      end else if (tick) begin
        con_cnt <= con_cnt + 16'h0001;
      end
    end
  end

  // Status LED blink generator and indication modes.
  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      blink_cnt <= 4'h0;
      blink     <= 1'b0;
      led_out   <= 1'b0;
    end else begin
      if (tick) begin
        if (blink_cnt >= `ZHC_BLINK_TICKS - 1) begin
          blink_cnt <= 4'h0;
          blink     <= ~blink;
        end else begin
          blink_cnt <= blink_cnt + 4'h1;
        end
      end
      case (led_mode_in)
        `ZHC_LED_CONTACT: led_out <= contact_out ? blink : 1'b1;   // [R20]
        `ZHC_LED_HEAT:    led_out <= underheat_out ? blink : 1'b1; // [R21]
        `ZHC_LED_ALARM:   led_out <= alarm_in ? blink : 1'b0;      // [R21]
        default:          led_out <= 1'b0;
      endcase
    end
  end

endmodule
`default_nettype wire

//--- pkg/zhc_consts.vh
// Constants for the zone heating control block.
`ifndef ZHC_CONSTS_VH
`define ZHC_CONSTS_VH
// Temperatures are signed tenths of a degree.
`define ZHC_TEMP_W        12
`define ZHC_HYST_MIN      8'h01
`define ZHC_HYST_MAX      8'h64
`define ZHC_CAL_MIN       8'h9C
`define ZHC_CAL_MAX       8'h64
`define ZHC_MAX_ACT       3'h6
// Operating mode codes.
`define ZHC_MODE_NORMAL   2'h0
`define ZHC_MODE_HOLIDAY  2'h1
`define ZHC_MODE_ECO      2'h2
`define ZHC_MODE_COMFORT  2'h3
// LED indication mode codes.
`define ZHC_LED_ALARM     2'h0
`define ZHC_LED_CONTACT   2'h1
`define ZHC_LED_HEAT      2'h2
// Timing: clock rate in MHz and timebase period in microseconds.
`define ZHC_CLK_MHZ       250
`define ZHC_TICK_US       100000
`define ZHC_TICK_CYC      (`ZHC_CLK_MHZ * `ZHC_TICK_US)
// Window delay limit in minutes, expressed in 0.1 s ticks.
`define ZHC_WIN_MAX_MIN   30
`define ZHC_WIN_MAX_TICK  (`ZHC_WIN_MAX_MIN * 600)
// Registration answer window in seconds, in ticks.
`define ZHC_REG_TIMEOUT_S 120
`define ZHC_REG_TICKS     (`ZHC_REG_TIMEOUT_S * 10)
// LED blink half period in ticks.
`define ZHC_BLINK_TICKS   5
`endif
